// file: verilog/serial_mode_pkg.sv
// Purpose: Shared constants for the serial transfer mode control block
// Assumes: APB slave, 32-bit data, byte addresses
// Notes: Mode register is 8 bits wide and sits in the low byte
package serial_mode_pkg;
  // Register byte offsets
  localparam logic [11:0] ADDR_MODE = 12'h000; // serial_mode_control
  localparam logic [11:0] ADDR_CTRL = 12'h004; // Format, role and start
  localparam logic [11:0] ADDR_DATA = 12'h008; // Transmit / receive byte
  // Mode register field positions
  localparam int BIT_ORDER_POS = 7; // bit_order_select
  localparam int WAIT_POS = 6; // Wait insertion
  localparam int WP_POS = 3; // counter_write_protect
  // Mode register reset value and fixed read-as-one bits
  localparam logic [7:0] MODE_RESET = 8'h38;
  localparam logic [1:0] RSVD_ONES = 2'h3;
  // Control register field positions and reset value
  localparam int CTRL_I2C_POS = 0; // 1: I2C format, 0: clocked synchronous
  localparam int CTRL_MASTER_POS = 1; // 1: master role
  localparam int CTRL_START_POS = 2; // Write 1 to start a transfer
  localparam int CTRL_BUSY_POS = 8; // Read-only busy flag
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // Transfer clock timing
  localparam int CLK_MHZ = 200; // pclk rate
  localparam int SCL_HALF_NS = 2500; // Half period of the transfer clock
  localparam int SCL_HALF_CYCLES = (SCL_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int WAIT_PERIODS = 2; // Stretched low length in transfer clocks
endpackage

// file: verilog/serial_transfer_mode_control.sv
// Purpose: Mode register and bit sequencer of a combined I2C / clocked serial port
// Assumes: APB master holds requests until pready; sda_in is an async pin
// Notes: Control at 0x004 and data at 0x008 drive the bit sequencer
`timescale 1ns/100ps
`default_nettype none
module serial_transfer_mode_control #(
  parameter int HALF_CYCLES = serial_mode_pkg::SCL_HALF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic busy
);
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW = 2'b01,
    ST_HIGH = 2'b10,
    ST_WAIT = 2'b11
  } seq_state_t;

  localparam logic [11:0] HALF_LOAD = 12'(HALF_CYCLES - 1);
  localparam logic [11:0] WAIT_LOAD = 12'(2 * serial_mode_pkg::WAIT_PERIODS * HALF_CYCLES - 1);
  logic pready_q; // Access-phase answer flag
  logic pslverr_q; // Unmapped address answer
  logic [31:0] prdata_q; // Captured read data
  logic bit_order_q; // bit_order_select
  logic wait_q; // Wait insertion enable
  logic [2:0] count_q; // transfer_bit_counter setting
  logic i2c_q; // Format select
  logic master_q; // Role select
  logic [7:0] tx_q; // Byte loaded at start
  seq_state_t state_q; // Sequencer state
  logic [11:0] phase_q; // Half-period down counter
  logic [3:0] left_q; // Bits remaining in transfer
  logic [7:0] sh_q; // Shift register
  logic scl_q; // Transfer clock out
  logic oe_q; // Drives sda low when set
  logic busy_q; // Transfer in progress
  logic sin_m_q; // Synchroniser first stage
  logic sin_q; // Synchronised serial input
  logic acc; // Access phase of a transfer
  logic wr_go; // Write takes effect
  logic start_go; // Start accepted
  logic ack_next; // Next bit is the I2C acknowledge
  logic wait_on; // Wait stretch applies
  logic [7:0] sh_next; // Shifter after one bit
  logic [31:0] rd_word; // Read mux

  // Bits per transfer from the counter code
  function automatic logic [3:0] decode_bits(input logic i2c, input logic [2:0] code);
    if (i2c) begin
      decode_bits = (code == 3'h0) ? 4'h9 : 4'({1'b0, code} + 4'h1);
    end else begin
      decode_bits = (code == 3'h0) ? 4'h8 : {1'b0, code};
    end
  endfunction
  // Counter code that stands for a remaining bit count
  function automatic logic [2:0] encode_bits(input logic i2c, input logic [3:0] bits);
    if (i2c) begin
      encode_bits = (bits == 4'h9) ? 3'h0 : 3'(bits - 4'h1);
    end else begin
      encode_bits = (bits == 4'h8) ? 3'h0 : bits[2:0];
    end
  endfunction
  assign acc = psel & penable;
  assign wr_go = acc & pready_q & pwrite;
  assign start_go = wr_go & (paddr == serial_mode_pkg::ADDR_CTRL)
    & pwdata[serial_mode_pkg::CTRL_START_POS] & (state_q == ST_IDLE);
  assign ack_next = i2c_q & (left_q == 4'h2);
  assign wait_on = wait_q & master_q & i2c_q;
  assign sh_next = bit_order_q ? {sin_q, sh_q[7:1]} : {sh_q[6:0], sin_q};

  // Read mux; counter field shows remaining bits while busy
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      serial_mode_pkg::ADDR_MODE: begin
        rd_word[7:0] = {bit_order_q, wait_q, serial_mode_pkg::RSVD_ONES, 1'b1,
          busy_q ? encode_bits(i2c_q, left_q) : count_q};
      end
      serial_mode_pkg::ADDR_CTRL: begin
        rd_word[serial_mode_pkg::CTRL_I2C_POS] = i2c_q;
        rd_word[serial_mode_pkg::CTRL_MASTER_POS] = master_q;
        rd_word[serial_mode_pkg::CTRL_BUSY_POS] = busy_q;
      end
      serial_mode_pkg::ADDR_DATA: begin
        rd_word[7:0] = sh_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // APB answer: one wait cycle, data and error captured with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= acc & ~pready_q;
      if (acc & ~pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr_q <= (paddr != serial_mode_pkg::ADDR_MODE)
          & (paddr != serial_mode_pkg::ADDR_CTRL) & (paddr != serial_mode_pkg::ADDR_DATA);
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Mode register; reserved and protect bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_order_q <= serial_mode_pkg::MODE_RESET[serial_mode_pkg::BIT_ORDER_POS];
      wait_q <= serial_mode_pkg::MODE_RESET[serial_mode_pkg::WAIT_POS];
      count_q <= serial_mode_pkg::MODE_RESET[2:0];
    end else if (wr_go & (paddr == serial_mode_pkg::ADDR_MODE)) begin
      bit_order_q <= pwdata[serial_mode_pkg::BIT_ORDER_POS];
      wait_q <= pwdata[serial_mode_pkg::WAIT_POS];
      if (!pwdata[serial_mode_pkg::WP_POS]) begin
        count_q <= pwdata[2:0];
      end
    end
  end

  // Control and transmit data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_q <= serial_mode_pkg::CTRL_RESET[0];
      master_q <= serial_mode_pkg::CTRL_RESET[1];
      tx_q <= 8'h00;
    end else if (wr_go) begin
      if (paddr == serial_mode_pkg::ADDR_CTRL) begin
        i2c_q <= pwdata[serial_mode_pkg::CTRL_I2C_POS];
        master_q <= pwdata[serial_mode_pkg::CTRL_MASTER_POS];
      end else if (paddr == serial_mode_pkg::ADDR_DATA) begin
        tx_q <= pwdata[7:0];
      end
    end
  end

  // Two-stage synchroniser for the serial data pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_m_q <= 1'b1;
      sin_q <= 1'b1;
    end else begin
      sin_m_q <= sda_in;
      sin_q <= sin_m_q;
    end
  end

  // Bit sequencer: low half, high half, optional stretch before ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      phase_q <= 12'h000;
      left_q <= 4'h0;
      sh_q <= 8'h00;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_go) begin
            // Format comes from the start write itself, so a format change there counts
            left_q <= decode_bits(pwdata[serial_mode_pkg::CTRL_I2C_POS], count_q);
            sh_q <= tx_q;
            oe_q <= ~(bit_order_q ? tx_q[0] : tx_q[7]);
            scl_q <= 1'b0;
            phase_q <= HALF_LOAD;
            busy_q <= 1'b1;
            state_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (phase_q == 12'h000) begin
            scl_q <= 1'b1;
            phase_q <= HALF_LOAD;
            state_q <= ST_HIGH;
          end else begin
            phase_q <= phase_q - 12'h001;
          end
        end
        ST_HIGH: begin
          if (phase_q != 12'h000) begin
            phase_q <= phase_q - 12'h001;
          end else if (left_q == 4'h1) begin
            // Last bit done: release the line
            left_q <= 4'h0;
            oe_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            sh_q <= sh_next;
            left_q <= left_q - 4'h1;
            scl_q <= 1'b0;
            oe_q <= ack_next ? 1'b0 : ~(bit_order_q ? sh_next[0] : sh_next[7]);
            if (ack_next & wait_on) begin
              phase_q <= WAIT_LOAD;
              state_q <= ST_WAIT;
            end else begin
              phase_q <= HALF_LOAD;
              state_q <= ST_LOW;
            end
          end
        end
        ST_WAIT: begin
          // Clock held low, then the acknowledge bit follows
          if (phase_q == 12'h000) begin
            phase_q <= HALF_LOAD;
            state_q <= ST_LOW;
          end else begin
            phase_q <= phase_q - 12'h001;
          end
        end
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign scl_out = scl_q;
  assign busy = busy_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_order;
    (state_q == ST_HIGH) && !ack_next && !(i2c_q && left_q == 4'h1)
      |-> oe_q == !(bit_order_q ? sh_q[0] : sh_q[7]);
  endproperty
  a_order: assert property (p_order) else $error("sda level not from selected bit end");
  property p_wait_len;
    (state_q == ST_HIGH) ##1 (state_q == ST_WAIT) |-> phase_q == WAIT_LOAD && !scl_q;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait stretch wrong length");
  property p_no_wait;
    (state_q == ST_HIGH) && phase_q == 12'h000 && ack_next && !wait_on |=> state_q == ST_LOW;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("ack delayed without wait");
  property p_wait_cause;
    (state_q == ST_WAIT) |-> master_q && i2c_q && wait_q && left_q == 4'h1;
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait entered when not allowed");
  property p_rsvd;
    $rose(pready_q) && !pwrite && paddr == serial_mode_pkg::ADDR_MODE |-> prdata_q[5:4] == 2'h3;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not read as one");
  property p_protect;
    wr_go && paddr == serial_mode_pkg::ADDR_MODE && pwdata[3] |=> $stable(count_q);
  endproperty
  a_protect: assert property (p_protect) else $error("protected counter changed");
  property p_wp_read;
    $rose(pready_q) && !pwrite && paddr == serial_mode_pkg::ADDR_MODE |-> prdata_q[3];
  endproperty
  a_wp_read: assert property (p_wp_read) else $error("write protect bit read as zero");
  property p_decode;
    start_go |=> left_q == (i2c_q ? (count_q == 3'h0 ? 4'h9 : 4'({1'b0, count_q} + 4'h1))
      : (count_q == 3'h0 ? 4'h8 : {1'b0, count_q}));
  endproperty
  a_decode: assert property (p_decode) else $error("bit count decode wrong");
  property p_remain;
    $rose(pready_q) && !pwrite && paddr == serial_mode_pkg::ADDR_MODE && $past(busy_q)
      |-> prdata_q[2:0] == encode_bits(i2c_q, $past(left_q));
  endproperty
  a_remain: assert property (p_remain) else $error("busy read not remaining count");
  c_start: cover property (start_go);
  c_wait: cover property (state_q == ST_WAIT);
  c_done: cover property ($fell(busy_q));
endmodule // serial_transfer_mode_control
`default_nettype wire

// file: test/serial_peer.sv
// Purpose: Serial peer model on the far side of the mode control block
// Assumes: Open-drain data line with pull-up; the peer never pulls low
// Notes: Records bits seen at clock rises and the longest low phase
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic pclk,
  input wire logic clr,
  input wire logic scl,
  input wire logic sda_oe,
  output logic sda_in,
  output logic [8:0] cap,
  output logic [7:0] bits,
  output logic [7:0] falls,
  output logic [7:0] max_low
);
  logic scl_q; // Clock level one cycle back
  logic [7:0] low_q; // Length of the current low phase
  // Pull-up wins unless the device pulls the line low
  assign sda_in = ~sda_oe;
  // Capture at rises, count falls, measure low phases
  always_ff @(posedge pclk) begin
    scl_q <= scl;
    if (clr) begin
      cap <= '0;
      bits <= '0;
      falls <= '0;
      max_low <= '0;
      low_q <= '0;
    end else begin
      low_q <= scl ? 8'h00 : low_q + 8'h01;
      if (!scl && low_q + 8'h01 > max_low) max_low <= low_q + 8'h01;
      if (scl && !scl_q) begin
        cap <= {cap[7:0], sda_in};
        bits <= bits + 8'h01;
      end
      if (!scl && scl_q) falls <= falls + 8'h01;
    end
  end
endmodule // serial_peer
`default_nettype wire

// file: test/test_serial_transfer_mode_control.sv
// Purpose: Self-checking bench for the serial transfer mode control block
// Assumes: APB access answers with pready; short transfer clock half period of 4 cycles
// Notes: Table rows cover formats, roles, orders and counts
`timescale 1ns/100ps
`default_nettype none
module test_serial_transfer_mode_control;
  localparam int H = 4; // Transfer clock half period in cycles
  typedef struct {logic [7:0] m; logic [1:0] c; logic [7:0] d; int n; logic w;} row_t;
  // Mode byte, format/role, data, bits per transfer, wait applies
  row_t rows [6] = '{'{8'h00, 2'h3, 8'hA6, 9, 1'b0}, '{8'h43, 2'h3, 8'h5C, 4, 1'b1},
    '{8'h47, 2'h1, 8'hC3, 8, 1'b0}, '{8'hC0, 2'h2, 8'h2D, 8, 1'b0},
    '{8'h01, 2'h2, 8'h80, 1, 1'b0}, '{8'h87, 2'h0, 8'h35, 7, 1'b0}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr;
  logic sda_in, sda_out, sda_oe, scl_out, busy, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] cap, ec;
  logic [7:0] bits, falls, max_low;
  int mismatches, checks;
  serial_transfer_mode_control #(.HALF_CYCLES(H)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .busy(busy));
  serial_peer u_peer (.pclk(pclk), .clr(clr), .scl(scl_out), .sda_oe(sda_oe),
    .sda_in(sda_in), .cap(cap), .bits(bits), .falls(falls), .max_low(max_low));
  // Free-running 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail(input string s);
    $display("CHECK FAILED %0t %s", $time, s);
    mismatches++;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string s);
    checks++;
    if (g !== e) fail(s);
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      fail("bus timeout");
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for the end of a transfer
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge pclk);
    while (busy !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      fail("transfer timeout");
      conclude();
    end
  endtask
  initial begin
    {psel, penable, pwrite, clr} = '0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    cmp({scl_out, sda_oe, busy, sda_out}, 4'h8, "idle pins");
    apb(1'b0, serial_mode_pkg::ADDR_MODE, '0);
    cmp(rd, 32'h38, "mode reset");
    apb(1'b0, 12'h00C, '0);
    cmp(er, 1'b1, "unmapped error");
    cmp(rd, 32'h0, "unmapped read");
    apb(1'b1, serial_mode_pkg::ADDR_MODE, 32'hFF);
    apb(1'b0, serial_mode_pkg::ADDR_MODE, '0);
    cmp(rd, 32'hF8, "protected count");
    apb(1'b1, serial_mode_pkg::ADDR_MODE, 32'h07);
    apb(1'b0, serial_mode_pkg::ADDR_MODE, '0);
    cmp(rd, 32'h3F, "count load");
    $display("register test done");
    foreach (rows[i]) begin
      apb(1'b1, serial_mode_pkg::ADDR_CTRL, 32'h1);
      apb(1'b1, serial_mode_pkg::ADDR_MODE, {25'h0, rows[i].m[6:0]});
      apb(1'b1, serial_mode_pkg::ADDR_DATA, {24'h0, rows[i].d});
      apb(1'b1, serial_mode_pkg::ADDR_CTRL, {30'h0, rows[i].c});
      apb(1'b1, serial_mode_pkg::ADDR_MODE, {24'h0, rows[i].m | 8'h08});
      clr <= 1'b1;
      apb(1'b1, serial_mode_pkg::ADDR_CTRL, {29'h1, rows[i].c});
      clr <= 1'b0;
      wait_idle();
      ec = '0;
      for (int k = 0; k < rows[i].n; k++)
        ec = {ec[7:0], (k < rows[i].n - rows[i].c[0]) ?
          (rows[i].m[7] ? rows[i].d[k] : rows[i].d[7-k]) : 1'b1};
      cmp(bits, rows[i].n, "bit count");
      cmp(cap, ec, "bit order");
      cmp(max_low, rows[i].w ? 5 * H : H, "low phase");
      $display("row %0d done", i);
    end
    clr <= 1'b1;
    apb(1'b1, serial_mode_pkg::ADDR_CTRL, 32'h6);
    clr <= 1'b0;
    for (int n = 0; falls !== 8'h05 && n < 400; n++) @(posedge pclk);
    if (falls !== 8'h05) begin
      fail("clock fall timeout");
      conclude();
    end
    apb(1'b0, serial_mode_pkg::ADDR_MODE, '0);
    cmp(rd[2:0], 3'h3, "remaining count");
    wait_idle();
    apb(1'b0, serial_mode_pkg::ADDR_MODE, '0);
    cmp(rd, 32'hBF, "setting kept");
    $display("remaining count test done");
    // Reset in the middle of a transfer must abort it and restore the mode register
    apb(1'b1, serial_mode_pkg::ADDR_CTRL, 32'h6);
    repeat (6) @(posedge pclk);
    cmp(busy, 1'b1, "busy before reset");
    presetn <= 1'b0;
    @(posedge pclk);
    cmp({scl_out, sda_oe, busy, sda_out}, 4'h8, "pins in reset");
    presetn <= 1'b1;
    apb(1'b0, serial_mode_pkg::ADDR_MODE, '0);
    cmp(rd, 32'h38, "mode after reset");
    $display("reset test done");
    conclude();
  end
endmodule // test_serial_transfer_mode_control
`default_nettype wire
